// file: verilog/clock_tree_map.vh
// register offsets, reset values and timing counts of the clock tree
`ifndef CLOCK_TREE_MAP_VH
`define CLOCK_TREE_MAP_VH
`define OFS_PRE_DIV 8'h00
`define OFS_MULT 8'h04
`define OFS_CORE_SYS 8'h08
`define OFS_CORE_PIX 8'h0C
`define OFS_OUT_BIT 8'h10
`define OFS_OUT_PIX 8'h14
`define OFS_FORMAT 8'h18
`define OFS_SIGNAL 8'h1C
`define OFS_MODE 8'h20
`define OFS_XSIZE 8'h24
`define OFS_STATUS 8'h28
`define OFS_EFFECT 8'h2C
`define RST_PRE_DIV 16'h0001
`define RST_MULT 16'h0040
`define RST_CORE_SYS 16'h0002
`define RST_CORE_PIX 16'h000A
`define RST_OUT_BIT 16'h0001
`define RST_OUT_PIX 16'h000A
`define RST_FORMAT 16'h0A0A
`define RST_SIGNAL 16'h0001
`define RST_XSIZE 16'h0640
`define CORE_SYS_FIXED 16'h0002
`define WIDTH_TEN 8'h0A
`define WIDTH_EIGHT 8'h08
`define LOCK_REF_CYCLES 6750
`define LOOP_SCALE 128
`define ST_STREAM_BIT 0
`define ST_LOCK_BIT 1
`endif

// file: verilog/pixel_clock_tree.v
// sensor clock divider tree with wishbone register file
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
`include "clock_tree_map.vh"
module pixel_clock_tree #(
    parameter LOCK_REF_CYCLES = `LOCK_REF_CYCLES,
    parameter LOOP_SCALE = `LOOP_SCALE
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg wb_ack_o,
    input wire external_reference_clock,
    output reg loop_output_clock,
    output reg core_system_clock,
    output reg core_pixel_clock,
    output reg output_bit_clock,
    output reg output_pixel_clock,
    output reg streaming,
    output reg lock_wait,
    output reg bit_both_edges,
    output reg pixel_width_ten,
    output reg pixel_compressed,
    output reg [23:0] line_data_bits
);

// ============================================================
// helpers
function [15:0] non_zero;
    input [15:0] v;
    begin
        non_zero = (v == 16'h0000) ? 16'h0001 : v;
    end
endfunction

function [15:0] wr16;
    input [15:0] old;
    input [31:0] d;
    input [3:0] sel;
    begin
        wr16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    end
endfunction

// ============================================================
// registers
localparam [2:0] ST_STANDBY = 3'b001;
localparam [2:0] ST_LOCK = 3'b010;
localparam [2:0] ST_STREAM = 3'b100;

reg [15:0] pre_div_reg;
reg [15:0] mult_reg;
reg [15:0] core_sys_div_reg;
reg [15:0] core_pix_div_reg;
reg [15:0] out_bit_div_reg;
reg [15:0] out_pix_div_reg;
reg [15:0] format_reg;
reg [15:0] signal_reg;
reg [15:0] mode_reg;
reg [15:0] xsize_reg;
reg [2:0] state_reg;
reg [2:0] state_next;
reg [15:0] lock_cnt_reg;
reg ref_meta_reg;
reg ref_sync_reg;
reg ref_prev_reg;
reg [23:0] acc_reg;
reg [15:0] sys_cnt_reg;
reg [15:0] pix_cnt_reg;
reg [15:0] bit_cnt_reg;
reg [15:0] opix_cnt_reg;
reg [31:0] rd_data;

wire access = wb_cyc_i & wb_stb_i;
wire wr_do = access & wb_ack_o & wb_we_i;
wire in_standby = (state_reg == ST_STANDBY);
wire div_wr = wr_do & in_standby;
wire [7:0] ofs = wb_adr_i[7:0];
wire strobe = signal_reg[0];
wire ten_bit = (format_reg[7:0] == `WIDTH_TEN);
wire ref_rise = ref_sync_reg & ~ref_prev_reg;

// ============================================================
// effective values
wire [15:0] mult_even = {mult_reg[15:1], 1'b0};
wire [15:0] mult_eff = strobe ? {1'b0, mult_even[15:1]} : mult_reg;
wire [15:0] pre_eff = non_zero(pre_div_reg);
wire [15:0] core_sys_eff = 16'h0001;
wire [15:0] core_pix_prog = non_zero(core_pix_div_reg);
wire [15:0] core_pix_eff = strobe ? core_pix_prog :
    {core_pix_prog[14:0], 1'b0};
wire [15:0] out_bit_eff = non_zero(out_bit_div_reg);
wire [7:0] bits_per_pix = ten_bit ? `WIDTH_TEN : `WIDTH_EIGHT;
wire [15:0] out_pix_eff = strobe ? {9'h000, bits_per_pix[7:1]} :
    {8'h00, bits_per_pix};
wire [23:0] acc_limit = pre_eff * LOOP_SCALE[7:0];
wire [23:0] acc_sum = acc_reg + {8'h00, mult_eff};

// ============================================================
// bus slave
always @* begin
    rd_data = 32'h0000_0000;
    case (ofs)
        `OFS_PRE_DIV: rd_data = {16'h0000, pre_div_reg};
        `OFS_MULT: rd_data = {16'h0000, mult_reg};
        `OFS_CORE_SYS: rd_data = {16'h0000, core_sys_div_reg};
        `OFS_CORE_PIX: rd_data = {16'h0000, core_pix_div_reg};
        `OFS_OUT_BIT: rd_data = {16'h0000, out_bit_div_reg};
        `OFS_OUT_PIX: rd_data = {16'h0000, out_pix_div_reg};
        `OFS_FORMAT: rd_data = {16'h0000, format_reg};
        `OFS_SIGNAL: rd_data = {16'h0000, signal_reg};
        `OFS_MODE: rd_data = {16'h0000, mode_reg};
        `OFS_XSIZE: rd_data = {16'h0000, xsize_reg};
        `OFS_STATUS: rd_data = {30'h0000_0000, state_reg == ST_LOCK,
            state_reg == ST_STREAM};
        `OFS_EFFECT: rd_data = {mult_eff, core_pix_eff[7:0],
            out_pix_eff[7:0]};
        default: rd_data = 32'h0000_0000;
    endcase
end

always @(posedge core_clk) begin
    if (sys_rst) begin
        wb_ack_o <= 1'b0;
        wb_dat_o <= 32'h0000_0000;
    end else begin
        wb_ack_o <= access & ~wb_ack_o;
        if (access & ~wb_ack_o)
            wb_dat_o <= rd_data;
    end
end

always @(posedge core_clk) begin
    if (sys_rst) begin
        pre_div_reg <= `RST_PRE_DIV;
        mult_reg <= `RST_MULT;
        core_sys_div_reg <= `RST_CORE_SYS;
        core_pix_div_reg <= `RST_CORE_PIX;
        out_bit_div_reg <= `RST_OUT_BIT;
        out_pix_div_reg <= `RST_OUT_PIX;
        format_reg <= `RST_FORMAT;
        signal_reg <= `RST_SIGNAL;
        mode_reg <= 16'h0000;
        xsize_reg <= `RST_XSIZE;
    end else begin
        if (div_wr) begin
            case (ofs)
                `OFS_PRE_DIV: pre_div_reg <= wr16(pre_div_reg, wb_dat_i,
                    wb_sel_i);
                `OFS_MULT: mult_reg <= wr16(mult_reg, wb_dat_i, wb_sel_i);
                `OFS_CORE_SYS: core_sys_div_reg <= wr16(core_sys_div_reg,
                    wb_dat_i, wb_sel_i);
                `OFS_CORE_PIX: core_pix_div_reg <= wr16(core_pix_div_reg,
                    wb_dat_i, wb_sel_i);
                `OFS_OUT_BIT: out_bit_div_reg <= wr16(out_bit_div_reg,
                    wb_dat_i, wb_sel_i);
                `OFS_OUT_PIX: out_pix_div_reg <= wr16(out_pix_div_reg,
                    wb_dat_i, wb_sel_i);
                `OFS_FORMAT: format_reg <= wr16(format_reg, wb_dat_i,
                    wb_sel_i);
                `OFS_SIGNAL: signal_reg <= wr16(signal_reg, wb_dat_i,
                    wb_sel_i);
                `OFS_XSIZE: xsize_reg <= wr16(xsize_reg, wb_dat_i,
                    wb_sel_i);
                default: mode_reg <= mode_reg;
            endcase
        end
        if (wr_do && ofs == `OFS_MODE && wb_sel_i[0])
            mode_reg <= {15'h0000, wb_dat_i[0]};
    end
end

// ============================================================
// streaming sequencer
always @* begin
    state_next = state_reg;
    case (state_reg)
        ST_STANDBY: if (mode_reg[0]) state_next = ST_LOCK;
        ST_LOCK: begin
            if (!mode_reg[0])
                state_next = ST_STANDBY;
            else if (ref_rise && lock_cnt_reg ==
                LOCK_REF_CYCLES[15:0] - 16'h0001)
                state_next = ST_STREAM;
        end
        ST_STREAM: if (!mode_reg[0]) state_next = ST_STANDBY;
        default: state_next = ST_STANDBY;
    endcase
end

always @(posedge core_clk) begin
    if (sys_rst) begin
        state_reg <= ST_STANDBY;
        lock_cnt_reg <= 16'h0000;
        ref_meta_reg <= 1'b0;
        ref_sync_reg <= 1'b0;
        ref_prev_reg <= 1'b0;
    end else begin
        state_reg <= state_next;
        ref_meta_reg <= external_reference_clock;
        ref_sync_reg <= ref_meta_reg;
        ref_prev_reg <= ref_sync_reg;
        if (state_reg != ST_LOCK)
            lock_cnt_reg <= 16'h0000;
        else if (ref_rise)
            lock_cnt_reg <= lock_cnt_reg + 16'h0001;
    end
end

// ============================================================
// divider chains, each tick one core_clk wide
always @(posedge core_clk) begin
    if (sys_rst || state_reg != ST_STREAM) begin
        acc_reg <= 24'h00_0000;
        sys_cnt_reg <= 16'h0000;
        pix_cnt_reg <= 16'h0000;
        bit_cnt_reg <= 16'h0000;
        opix_cnt_reg <= 16'h0000;
        loop_output_clock <= 1'b0;
        core_system_clock <= 1'b0;
        core_pixel_clock <= 1'b0;
        output_bit_clock <= 1'b0;
        output_pixel_clock <= 1'b0;
    end else begin
        // rate mult_eff / (pre_eff * scale) of core_clk
        loop_output_clock <= (acc_sum >= acc_limit);
        acc_reg <= (acc_sum >= acc_limit) ? acc_sum - acc_limit : acc_sum;
        core_system_clock <= 1'b0;
        core_pixel_clock <= 1'b0;
        output_bit_clock <= 1'b0;
        output_pixel_clock <= 1'b0;
        if (loop_output_clock) begin
            if (sys_cnt_reg >= core_sys_eff - 16'h0001) begin
                sys_cnt_reg <= 16'h0000;
                core_system_clock <= 1'b1;
            end else
                sys_cnt_reg <= sys_cnt_reg + 16'h0001;
            if (bit_cnt_reg >= out_bit_eff - 16'h0001) begin
                bit_cnt_reg <= 16'h0000;
                output_bit_clock <= 1'b1;
            end else
                bit_cnt_reg <= bit_cnt_reg + 16'h0001;
        end
        if (core_system_clock) begin
            if (pix_cnt_reg >= core_pix_eff - 16'h0001) begin
                pix_cnt_reg <= 16'h0000;
                core_pixel_clock <= 1'b1;
            end else
                pix_cnt_reg <= pix_cnt_reg + 16'h0001;
        end
        if (output_bit_clock) begin
            if (opix_cnt_reg >= out_pix_eff - 16'h0001) begin
                opix_cnt_reg <= 16'h0000;
                output_pixel_clock <= 1'b1;
            end else
                opix_cnt_reg <= opix_cnt_reg + 16'h0001;
        end
    end
end

// ============================================================
// status and format outputs
always @(posedge core_clk) begin
    if (sys_rst) begin
        streaming <= 1'b0;
        lock_wait <= 1'b0;
        bit_both_edges <= 1'b0;
        pixel_width_ten <= 1'b0;
        pixel_compressed <= 1'b0;
        line_data_bits <= 24'h00_0000;
    end else begin
        streaming <= (state_reg == ST_STREAM);
        lock_wait <= (state_reg == ST_LOCK);
        bit_both_edges <= strobe;
        pixel_width_ten <= ten_bit;
        pixel_compressed <= ~ten_bit &&
            format_reg[15:8] == `WIDTH_TEN;
        line_data_bits <= xsize_reg * bits_per_pix;
    end
end

endmodule // pixel_clock_tree

// file: dv/clock_tree_props.sv
// assertion checker for the clock tree ports
`timescale 1ns/1ps
module clock_tree_props #(
    parameter LOCK_REF_CYCLES = 6750,
    parameter LOOP_SCALE = 128
) (
    input wire core_clk,
    input wire sys_rst,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire loop_output_clock,
    input wire core_system_clock,
    input wire core_pixel_clock,
    input wire output_bit_clock,
    input wire output_pixel_clock,
    input wire streaming,
    input wire lock_wait,
    input wire bit_both_edges,
    input wire pixel_width_ten,
    input wire pixel_compressed
);
    // ==========================================
    // properties
    default clocking @(posedge core_clk); endclocking
    default disable iff (sys_rst);
    wire ticks = loop_output_clock | core_system_clock | core_pixel_clock |
        output_bit_clock | output_pixel_clock;
    a_ack_answer: assert property (
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
    a_ack_single: assert property (
        wb_ack_o |=> !wb_ack_o) else $error("ack too long");
    a_ack_cause: assert property (
        wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    a_idle_quiet: assert property (
        !streaming && !$past(streaming) |-> !ticks) else $error("idle tick");
    a_lock_before: assert property (
        $rose(streaming) |-> $past(lock_wait)) else $error("lock skipped");
    a_state_excl: assert property (
        !(streaming && lock_wait)) else $error("two states");
    a_mode_start: assert property (
        wb_ack_o && wb_we_i && wb_adr_i[7:0] == 8'h20 && wb_dat_i[0] &&
        wb_sel_i[0] && !streaming && !lock_wait |-> ##[1:3] lock_wait)
        else $error("mode write ignored");
    a_edges_hold: assert property (
        streaming && $past(streaming) |-> $stable(bit_both_edges))
        else $error("mode changed in stream");
    a_format_excl: assert property (
        !(pixel_width_ten && pixel_compressed)) else $error("two formats");
    // bit ticks seen since the last output pixel tick
    reg [7:0] bit_seen;
    always @(posedge core_clk) begin
        if (sys_rst || !streaming) begin
            bit_seen <= 8'h00;
        end else if (output_pixel_clock) begin
            bit_seen <= {7'h00, output_bit_clock};
        end else if (output_bit_clock) begin
            bit_seen <= bit_seen + 8'h01;
        end
    end
    a_bit_ratio: assert property (
        output_pixel_clock && streaming |-> bit_seen == (pixel_width_ten ?
        (bit_both_edges ? 8'h05 : 8'h0A) : (bit_both_edges ? 8'h04 : 8'h08)))
        else $error("bit to pixel ratio wrong");
endmodule // clock_tree_props

// file: dv/ref_clock_source.sv
// free running external reference clock
`timescale 1ns/1ps
module ref_clock_source (
    output logic refclk
);
    // 80 ns period, far below a third of the core rate
    initial refclk = 1'b0;
    always #40 refclk = ~refclk;
endmodule // ref_clock_source

// file: dv/sensor_pixel_clock_divider_tree_test.sv
// bench for the clock tree over its register bus
`timescale 1ns/1ps
module sensor_pixel_clock_divider_tree_test;
    logic core_clk = 1'b0, sys_rst = 1'b1, wb_we_i = 1'b0;
    logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
    logic [31:0] wb_adr_i = 32'h0, wb_dat_i = 32'h0, q;
    logic [3:0] wb_sel_i = 4'h0;
    logic [15:0] rv [10] = '{16'h0001, 16'h0040, 16'h0002, 16'h000A,
        16'h0001, 16'h000A, 16'h0A0A, 16'h0001, 16'h0000, 16'h0640};
    wire [31:0] wb_dat_o;
    wire [23:0] line_data_bits;
    wire wb_ack_o, ref_clk, loop_output_clock, core_system_clock;
    wire core_pixel_clock, output_bit_clock, output_pixel_clock, streaming;
    wire lock_wait, bit_both_edges, pixel_width_ten, pixel_compressed;
    integer bad_count = 0, compares = 0, n;
    always #4 core_clk = ~core_clk;
    ref_clock_source partner (.refclk(ref_clk));
    pixel_clock_tree #(.LOCK_REF_CYCLES(4)) DUT (.core_clk(core_clk),
        .sys_rst(sys_rst), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .external_reference_clock(ref_clk),
        .loop_output_clock(loop_output_clock),
        .core_system_clock(core_system_clock),
        .core_pixel_clock(core_pixel_clock),
        .output_bit_clock(output_bit_clock),
        .output_pixel_clock(output_pixel_clock), .streaming(streaming),
        .lock_wait(lock_wait), .bit_both_edges(bit_both_edges),
        .pixel_width_ten(pixel_width_ten),
        .pixel_compressed(pixel_compressed), .line_data_bits(line_data_bits));
    // ==========================================
    // checking and bus tasks
    task end_sim;
        $display("compares %0d, bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task chk(input [31:0] seen, input [31:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task wait_fail;
        bad_count++;
        $display("unexpected timeout at %0t", $time);
        end_sim;
    endtask
    task wb(input w, input [7:0] a, input [15:0] d);
        integer i;
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= w;
        wb_adr_i <= {24'h000000, a};
        wb_dat_i <= {16'h0000, d};
        wb_sel_i <= 4'hF;
        for (i = 0; i < 20 && wb_ack_o !== 1'b1; i++) @(posedge core_clk);
        if (wb_ack_o !== 1'b1) wait_fail;
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask
    task rchk(input [7:0] a, input [31:0] e);
        wb(1'b0, a, 16'h0000);
        chk(q, e);
    endtask
    task cfg(input [15:0] f, s, p, m, c, o);
        wb(1'b1, 8'h18, f);
        wb(1'b1, 8'h1C, s);
        wb(1'b1, 8'h00, p);
        wb(1'b1, 8'h04, m);
        wb(1'b1, 8'h0C, c);
        wb(1'b1, 8'h10, 16'h0001);
        wb(1'b1, 8'h14, o);
    endtask
    task start;
        integer i, l;
        l = 0;
        wb(1'b1, 8'h20, 16'h0001);
        for (i = 0; i < 400 && streaming !== 1'b1; i++) begin
            @(posedge core_clk);
            if (lock_wait === 1'b1) l = 1;
        end
        if (streaming !== 1'b1) wait_fail;
        chk(l, 1);
    endtask
    // loop ticks over a window of whole accumulator periods
    task loops(input integer len, input [31:0] e);
        integer i, c;
        c = 0;
        for (i = 0; i < len; i++) begin
            @(posedge core_clk);
            if (loop_output_clock === 1'b1) c++;
        end
        chk(c, e);
    endtask
    // fast ticks over four slow tick periods
    task ratio(input s, input [31:0] e);
        integer i, k, c;
        k = -1;
        c = 0;
        for (i = 0; i < 4000 && k < 4; i++) begin
            @(posedge core_clk);
            if (k >= 0 && (s ? core_system_clock : output_bit_clock)) c++;
            if (s ? core_pixel_clock : output_pixel_clock) k++;
        end
        if (k < 4) wait_fail;
        chk(c, 4 * e);
    endtask
    // ==========================================
    // scenarios
    initial begin
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        for (n = 0; n < 10; n++) rchk(8'(n * 4), {16'h0000, rv[n]});
        rchk(8'h28, 32'h00000000);
        rchk(8'h30, 32'h00000000);
        cfg(16'h0A0A, 16'h0001, 16'h0002, 16'h0051, 16'h0005,
            16'h000A);
        rchk(8'h04, 32'h00000051);
        rchk(8'h2C, 32'h00280505);
        start;
        chk({31'h0, pixel_width_ten}, 32'h1);
        chk({31'h0, bit_both_edges}, 32'h1);
        chk({8'h00, line_data_bits}, 32'h00003E80);
        ratio(1'b0, 32'h5);
        ratio(1'b1, 32'h5);
        loops(256, 32'h28);
        rchk(8'h28, 32'h00000001);
        wb(1'b1, 8'h00, 16'h0007);
        rchk(8'h00, 32'h00000002);
        wb(1'b1, 8'h20, 16'h0000);
        cfg(16'h0808, 16'h0000, 16'h0004, 16'h0034, 16'h0002,
            16'h0008);
        wb(1'b1, 8'h24, 16'h0320);
        rchk(8'h2C, 32'h00340408);
        start;
        chk({8'h00, line_data_bits}, 32'h00001900);
        ratio(1'b0, 32'h8);
        ratio(1'b1, 32'h4);
        loops(512, 32'h34);
        wb(1'b1, 8'h20, 16'h0000);
        wb(1'b1, 8'h18, 16'h0A08);
        repeat (2) @(posedge core_clk);
        chk({31'h0, pixel_compressed}, 32'h1);
        end_sim;
    end
endmodule // sensor_pixel_clock_divider_tree_test
bind pixel_clock_tree clock_tree_props #(.LOCK_REF_CYCLES(LOCK_REF_CYCLES),
    .LOOP_SCALE(LOOP_SCALE)) props (.core_clk(core_clk), .sys_rst(sys_rst),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i),
    .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .loop_output_clock(loop_output_clock),
    .core_system_clock(core_system_clock),
    .core_pixel_clock(core_pixel_clock), .output_bit_clock(output_bit_clock),
    .output_pixel_clock(output_pixel_clock), .streaming(streaming),
    .lock_wait(lock_wait), .bit_both_edges(bit_both_edges),
    .pixel_width_ten(pixel_width_ten), .pixel_compressed(pixel_compressed));
